// ---- logic/stss_pkg.sv ----
// ****************************************************************
// shared constants of the serial tag port
// ****************************************************************
package stss_pkg;
  // clock and timing
  localparam int CLK_HZ = 20_000_000;
  localparam int SCK_MAX_HZ = 128_000;
  // least half period, rounded up so the serial clock stays below its limit
  localparam int SCK_HALF_CYC = (CLK_HZ + 2 * SCK_MAX_HZ - 1) / (2 * SCK_MAX_HZ);
  localparam logic [7:0] SCK_HALF_LAST = 8'(SCK_HALF_CYC - 1);
  localparam int WRITE_TIME_US = 100;
  localparam int WRITE_CYC = WRITE_TIME_US * (CLK_HZ / 1_000_000);
  localparam logic [11:0] WRITE_LAST = 12'(WRITE_CYC - 1);

  // opcodes, printed in binary as 00000101, 00000010, 00000011, 10000010, 10000011
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_MEM_WRITE = 8'h02;
  localparam logic [7:0] OP_MEM_READ = 8'h03;
  localparam logic [7:0] OP_REG_WRITE = 8'h82;
  localparam logic [7:0] OP_REG_READ = 8'h83;

  // field lengths, as last bit index of a field; frame lengths as whole bit counts
  localparam logic [4:0] BYTE_LAST = 5'h07;
  localparam logic [4:0] WORD_LAST = 5'h0F;
  localparam logic [5:0] FRAME_SHORT = 6'h10;
  localparam logic [5:0] FRAME_LONG = 6'h20;

  // register addresses
  localparam logic [7:0] REG_TEST = 8'h00;
  localparam logic [7:0] REG_CHECKSUM = 8'h01;
  localparam logic [7:0] REG_ID_HIGH = 8'h02;
  localparam logic [7:0] REG_ID_LOW = 8'h03;
  localparam logic [7:0] REG_XID_HEADER = 8'h04;
  localparam logic [7:0] REG_SENSOR = 8'h05;
  localparam logic [7:0] REG_TEMPERATURE = 8'h06;
  localparam logic [7:0] REG_TRIM0 = 8'h07;
  localparam logic [7:0] REG_CFG0 = 8'h08;
  localparam logic [7:0] REG_CFG1 = 8'h09;
  localparam logic [7:0] REG_CFG2 = 8'h0A;

  // reset values and field positions
  localparam logic [15:0] TEST_RESET = 16'h0000;
  localparam logic [15:0] TRIM_CFG_RESET = 16'h0000;
  localparam int TEST_TRIG_BIT = 15;
  localparam int STATUS_BUSY_BIT = 0;

  // controller registers on the apb side
  localparam logic [7:0] APB_CTRL = 8'h00;
  localparam logic [7:0] APB_CMD = 8'h04;
  localparam logic [7:0] APB_WDATA = 8'h08;
  localparam logic [7:0] APB_RDATA = 8'h0C;
  localparam logic [7:0] APB_STATUS = 8'h10;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_EN_BIT = 1;
  localparam int CTRL_RSTN_BIT = 2;
endpackage

// ---- logic/stss_if.sv ----
`timescale 1ns/1ns
// ****************************************************************
// serial link between controller and tag
// ****************************************************************
interface stss_if;
  logic spi_en;
  logic external_core_reset_n;
  logic sck;
  logic ncs;
  logic mosi;
  logic miso_out;
  logic miso_oe_n;
  logic miso;
  // undriven data line reads low in this model
  assign miso = miso_oe_n ? 1'b0 : miso_out;
  modport device (input spi_en, external_core_reset_n, sck, ncs, mosi,
                  output miso_out, miso_oe_n);
  modport host (output spi_en, external_core_reset_n, sck, ncs, mosi,
                input miso);
endinterface

// ---- logic/stss_device.sv ----
`timescale 1ns/1ns
module stss_device #(
  parameter logic [15:0] CHECKSUM_VAL = 16'hA5A5, // arbitrary value
  parameter logic [15:0] ID_HIGH_VAL = 16'h0F0F, // arbitrary value
  parameter logic [15:0] ID_LOW_VAL = 16'h3C3C, // arbitrary value
  parameter logic [15:0] XID_HEADER_VAL = 16'h5A5A // arbitrary value
) (
  input wire logic pclk,
  input wire logic presetn,
  stss_if.device link,
  input wire logic [15:0] sensor_value,
  input wire logic [15:0] temperature_value,
  output logic radio_enable,
  output logic ext_clock_select,
  output logic acquire_pulse,
  output logic [15:0] test_value,
  output logic [15:0] trim_value,
  output logic [15:0] config0_value,
  output logic [15:0] config1_value,
  output logic [15:0] config2_value
);
  import stss_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_WDATA, ST_ROUT, ST_WAIT} stss_dev_st_t;

  typedef struct packed {
    logic [1:0] en_s;
    logic [1:0] rst_s;
    logic [1:0] sck_s;
    logic [1:0] ncs_s;
    logic [1:0] mosi_s;
    logic sck_prev;
    stss_dev_st_t st;
    logic [4:0] bits;
    logic [7:0] op;
    logic [7:0] addr;
    logic [15:0] in_sr;
    logic [15:0] out_sr;
    logic miso;
    logic mem_pend;
    logic [7:0] waddr;
    logic [15:0] wdata;
    logic busy;
    logic [11:0] busy_cnt;
    logic acq;
    logic [15:0] test;
    logic [15:0] trim;
    logic [15:0] cfg0;
    logic [15:0] cfg1;
    logic [15:0] cfg2;
  } stss_dev_state_t;

  stss_dev_state_t q;
  stss_dev_state_t d;
  logic [15:0] mem [0:255];
  logic mem_we;
  logic rise;
  logic fall;
  logic sel;
  logic [15:0] nsr;

  // register read decode, every address of the map answers
  function automatic logic [15:0] stss_reg_read(input logic [7:0] a,
                                                input stss_dev_state_t s,
                                                input logic [15:0] sens,
                                                input logic [15:0] temp);
    logic [15:0] v;
    v = 16'h0000;
    if (a == REG_TEST) begin
      v = s.test;
    end else if (a == REG_CHECKSUM) begin
      v = CHECKSUM_VAL;
    end else if (a == REG_ID_HIGH) begin
      v = ID_HIGH_VAL;
    end else if (a == REG_ID_LOW) begin
      v = ID_LOW_VAL;
    end else if (a == REG_XID_HEADER) begin
      v = XID_HEADER_VAL;
    end else if (a == REG_SENSOR) begin
      v = sens;
    end else if (a == REG_TEMPERATURE) begin
      v = temp;
    end else if (a == REG_TRIM0) begin
      v = s.trim;
    end else if (a == REG_CFG0) begin
      v = s.cfg0;
    end else if (a == REG_CFG1) begin
      v = s.cfg1;
    end else if (a == REG_CFG2) begin
      v = s.cfg2;
    end
    return v;
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  // pins are sampled twice; edges are found on the second stage only
  always_comb begin
    d = q;
    mem_we = 1'b0;
    d.acq = 1'b0;
    d.en_s = {q.en_s[0], link.spi_en};
    d.rst_s = {q.rst_s[0], link.external_core_reset_n};
    d.sck_s = {q.sck_s[0], link.sck};
    d.ncs_s = {q.ncs_s[0], link.ncs};
    d.mosi_s = {q.mosi_s[0], link.mosi};
    d.sck_prev = q.sck_s[1];
    rise = q.sck_s[1] & ~q.sck_prev;
    fall = ~q.sck_s[1] & q.sck_prev;
    sel = q.en_s[1] & ~q.ncs_s[1];
    nsr = {q.in_sr[14:0], q.mosi_s[1]};
    // memory write cycle timer
    if (q.busy) begin
      d.busy_cnt = q.busy_cnt + 12'h001;
      if (q.busy_cnt == WRITE_LAST) begin
        d.busy = 1'b0;
      end
    end
    if (!sel) begin
      // a completed memory write is committed only at deselect
      if (q.st == ST_WAIT && q.mem_pend) begin
        mem_we = 1'b1;
        d.busy = 1'b1;
        d.busy_cnt = 12'h000;
      end
      d.st = ST_CMD;
      d.bits = 5'h00;
      d.mem_pend = 1'b0;
      d.miso = 1'b0;
    end else if (rise) begin
      d.in_sr = nsr;
      d.bits = q.bits + 5'h01;
      // no lock or tag state is consulted anywhere below
      case (q.st)
        ST_CMD: begin
          if (q.bits == BYTE_LAST) begin
            d.op = nsr[7:0];
            d.bits = 5'h00;
            case (nsr[7:0])
              OP_STATUS_READ: begin
                d.out_sr = 16'h0000;
                d.out_sr[8 + STATUS_BUSY_BIT] = q.busy;
                d.st = ST_ROUT;
              end
              OP_MEM_WRITE, OP_MEM_READ: begin
                d.st = q.busy ? ST_WAIT : ST_ADDR;
              end
              OP_REG_WRITE, OP_REG_READ: begin
                d.st = ST_ADDR;
              end
              default: begin
                d.st = ST_WAIT;
              end
            endcase
          end
        end
        ST_ADDR: begin
          if (q.bits == BYTE_LAST) begin
            d.addr = nsr[7:0];
            d.bits = 5'h00;
            if (q.op == OP_MEM_READ) begin
              d.out_sr = mem[nsr[7:0]];
              d.st = ST_ROUT;
            end else if (q.op == OP_REG_READ) begin
              d.out_sr = stss_reg_read(nsr[7:0], q, sensor_value, temperature_value);
              d.st = ST_ROUT;
            end else begin
              d.st = ST_WDATA;
            end
          end
        end
        ST_WDATA: begin
          if (q.bits == WORD_LAST) begin
            d.st = ST_WAIT;
            if (q.op == OP_MEM_WRITE) begin
              // trim and config words here land in memory only
              d.mem_pend = 1'b1;
              d.waddr = q.addr;
              d.wdata = nsr;
            end else if (q.addr == REG_TEST) begin
              d.test = nsr;
              d.acq = nsr[TEST_TRIG_BIT];
            end else if (q.addr == REG_TRIM0) begin
              d.trim = nsr;
            end else if (q.addr == REG_CFG0) begin
              d.cfg0 = nsr;
            end else if (q.addr == REG_CFG1) begin
              d.cfg1 = nsr;
            end else if (q.addr == REG_CFG2) begin
              d.cfg2 = nsr;
            end
          end
        end
        default: begin
        end
      endcase
    end else if (fall && q.st == ST_ROUT) begin
      // word was loaded at the last input edge, so msb leads here
      d.miso = q.out_sr[15];
      d.out_sr = {q.out_sr[14:0], 1'b0};
    end
    // external reset acts only in serial mode
    if (q.en_s[1] && !q.rst_s[1]) begin
      d.st = ST_CMD;
      d.bits = 5'h00;
      d.mem_pend = 1'b0;
      d.miso = 1'b0;
      d.busy = 1'b0;
      d.busy_cnt = 12'h000;
      d.acq = 1'b0;
      d.test = TEST_RESET;
      d.trim = TRIM_CFG_RESET;
      d.cfg0 = TRIM_CFG_RESET;
      d.cfg1 = TRIM_CFG_RESET;
      d.cfg2 = TRIM_CFG_RESET;
    end
  end

  // ****************************************************************
  // registers and memory
  // ****************************************************************
  // state flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.test <= TEST_RESET;
      q.trim <= TRIM_CFG_RESET;
      q.cfg0 <= TRIM_CFG_RESET;
      q.cfg1 <= TRIM_CFG_RESET;
      q.cfg2 <= TRIM_CFG_RESET;
    end else begin
      q <= d;
    end
  end

  // memory array has no reset, as real nonvolatile storage would not
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem[q.waddr] <= q.wdata;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // radio mode holds the line low; serial mode releases it when deselected
  assign link.miso_out = q.en_s[1] ? q.miso : 1'b0;
  assign link.miso_oe_n = q.en_s[1] & q.ncs_s[1];
  assign radio_enable = ~q.en_s[1];
  assign ext_clock_select = q.en_s[1];
  assign acquire_pulse = q.acq;
  assign test_value = q.test;
  assign trim_value = q.trim;
  assign config0_value = q.cfg0;
  assign config1_value = q.cfg1;
  assign config2_value = q.cfg2;
endmodule

// ---- logic/stss_host.sv ----
`timescale 1ns/1ns
module stss_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  stss_if.host link
);
  import stss_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [1:0] {H_IDLE, H_RUN, H_GAP} stss_host_st_t;

  typedef struct packed {
    stss_host_st_t st;
    logic spi_en;
    logic rst_n;
    logic [7:0] op;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [7:0] div;
    logic sck;
    logic ncs;
    logic mosi;
    logic [31:0] tx_sr;
    logic [15:0] rx_sr;
    logic [5:0] bitn;
    logic [5:0] nbits;
    logic [1:0] miso_s;
    logic [31:0] prdata;
    logic pslverr;
  } stss_host_state_t;

  stss_host_state_t q;
  stss_host_state_t d;
  logic wr;
  logic setup;
  logic hit;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    d = q;
    d.miso_s = {q.miso_s[0], link.miso};
    wr = psel & penable & pwrite;
    setup = psel & ~penable;
    hit = (paddr == APB_CTRL) || (paddr == APB_CMD) || (paddr == APB_WDATA) ||
          (paddr == APB_RDATA) || (paddr == APB_STATUS);
    // read data and error are prepared in setup, shown in the access cycle
    if (setup) begin
      d.pslverr = ~hit;
      d.prdata = 32'h00000000;
      if (paddr == APB_CTRL) begin
        d.prdata[CTRL_EN_BIT] = q.spi_en;
        d.prdata[CTRL_RSTN_BIT] = q.rst_n;
      end else if (paddr == APB_CMD) begin
        d.prdata[15:0] = {q.addr, q.op};
      end else if (paddr == APB_WDATA) begin
        d.prdata[15:0] = q.wdata;
      end else if (paddr == APB_RDATA) begin
        d.prdata[15:0] = q.rdata;
      end else if (paddr == APB_STATUS) begin
        d.prdata[0] = (q.st != H_IDLE);
      end
    end
    if (wr) begin
      if (paddr == APB_CTRL) begin
        d.spi_en = pwdata[CTRL_EN_BIT];
        d.rst_n = pwdata[CTRL_RSTN_BIT];
        // start is ignored while a frame is running
        if (pwdata[CTRL_START_BIT] && q.st == H_IDLE) begin
          d.st = H_RUN;
          d.ncs = 1'b0;
          d.sck = 1'b0;
          d.div = 8'h00;
          d.bitn = 6'h00;
          d.tx_sr = {q.op, q.addr, q.wdata};
          d.mosi = q.op[7];
          d.nbits = (q.op == OP_STATUS_READ) ? FRAME_SHORT : FRAME_LONG;
        end
      end else if (paddr == APB_CMD) begin
        d.op = pwdata[7:0];
        d.addr = pwdata[15:8];
      end else if (paddr == APB_WDATA) begin
        d.wdata = pwdata[15:0];
      end
    end
    // serial clock from a divider, half period rounded up
    if (q.st != H_IDLE) begin
      d.div = q.div + 8'h01;
      if (q.div == SCK_HALF_LAST) begin
        d.div = 8'h00;
        if (q.st == H_GAP) begin
          d.st = H_IDLE;
        end else if (!q.sck) begin
          d.sck = 1'b1;
          d.rx_sr = {q.rx_sr[14:0], q.miso_s[1]};
          d.bitn = q.bitn + 6'h01;
        end else begin
          d.sck = 1'b0;
          if (q.bitn == q.nbits) begin
            d.ncs = 1'b1;
            d.rdata = q.rx_sr;
            d.st = H_GAP;
          end else begin
            d.tx_sr = {q.tx_sr[30:0], 1'b0};
            d.mosi = q.tx_sr[30];
          end
        end
      end
    end
  end

  // ****************************************************************
  // registers and outputs
  // ****************************************************************
  // controller flip-flops; core reset is held low until software lifts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.ncs <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pslverr = q.pslverr;
  assign pready = 1'b1;
  assign link.spi_en = q.spi_en;
  assign link.external_core_reset_n = q.rst_n;
  assign link.sck = q.sck;
  assign link.ncs = q.ncs;
  assign link.mosi = q.mosi;
endmodule

// ---- testbench/stss_link_sva.sv ----
`timescale 1ns/1ns
// ****************************************************************
// wire-level checks on the serial link between the two ends
// ****************************************************************
module stss_link_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic spi_en,
  input wire logic external_core_reset_n,
  input wire logic sck,
  input wire logic ncs,
  input wire logic mosi,
  input wire logic miso_out,
  input wire logic miso_oe_n,
  input wire logic miso
);
  import stss_pkg::*;
  logic sck_q;
  logic [7:0] span_q;
  logic [5:0] bits_q;

  // length of the current serial clock level, and rising edges seen in this frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_q <= 1'b0;
      span_q <= 8'h00;
      bits_q <= 6'h00;
    end else begin
      sck_q <= sck;
      if (sck != sck_q) begin
        span_q <= 8'h00;
      end else if (span_q != 8'hFF) begin
        span_q <= span_q + 8'h01; // saturates so long idle gaps do not wrap
      end
      if (ncs) begin
        bits_q <= 6'h00;
      end else if (sck && !sck_q) begin
        bits_q <= bits_q + 6'h01;
      end
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_sck_idle_low: assert property (ncs |-> !sck)
    else $error("serial clock high while deselected");
  a_mosi_hold_high: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("data in changed while serial clock high");
  a_miso_hold_high: assert property (sck && $past(sck) && !miso_oe_n |-> $stable(miso_out))
    else $error("data out changed while serial clock high");
  // a level of 79 cycles shows here as a count of 78
  a_sck_slow_enough: assert property ((sck != sck_q) |-> span_q >= 8'h4E)
    else $error("serial clock level too short");
  a_frame_whole_bytes: assert property ($rose(ncs) |-> bits_q[2:0] == 3'h0)
    else $error("frame not a whole number of bytes");
  a_frame_length: assert property ($rose(ncs) |-> bits_q == FRAME_SHORT || bits_q == FRAME_LONG)
    else $error("frame length neither 16 nor 32 bits");
  a_radio_drive_low: assert property (!spi_en [*6] |-> !miso_oe_n && !miso_out)
    else $error("data out not driven low in radio mode");
  a_deselect_release: assert property ((spi_en && ncs) [*6] |-> miso_oe_n)
    else $error("data out still driven while deselected");
  a_select_starts_low: assert property ($fell(ncs) |-> !sck [*8])
    else $error("serial clock rose too soon after select");
endmodule

// ---- testbench/sensor_tag_spi_slave_tb.sv ----
`timescale 1ns/1ns
module sensor_tag_spi_slave_tb;
  import stss_pkg::*;
  localparam logic [15:0] CHK_V = 16'h1111; // arbitrary value
  localparam logic [15:0] IDH_V = 16'h2222; // arbitrary value
  localparam logic [15:0] IDL_V = 16'h3333; // arbitrary value
  localparam logic [15:0] XID_V = 16'h4444; // arbitrary value
  localparam logic [15:0] SENS_V = 16'h1357;
  localparam logic [15:0] TEMP_V = 16'h2468;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] sensor_value = SENS_V;
  logic [15:0] temperature_value = TEMP_V;
  logic radio_enable, ext_clock_select, acquire_pulse;
  logic [15:0] test_value, trim_value, config0_value, config1_value, config2_value;
  logic [31:0] r;
  logic perr;
  logic [15:0] rd;
  logic [15:0] exp_ro [1:6] = '{CHK_V, IDH_V, IDL_V, XID_V, SENS_V, TEMP_V};
  int error_cnt = 0;
  int n_tests = 0;
  int acq_cnt = 0;

  stss_if link();
  stss_host i_stss_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  stss_device #(.CHECKSUM_VAL(CHK_V), .ID_HIGH_VAL(IDH_V), .ID_LOW_VAL(IDL_V),
    .XID_HEADER_VAL(XID_V)) i_stss_device (.pclk(pclk), .presetn(presetn), .link(link),
    .sensor_value(sensor_value), .temperature_value(temperature_value),
    .radio_enable(radio_enable), .ext_clock_select(ext_clock_select),
    .acquire_pulse(acquire_pulse), .test_value(test_value), .trim_value(trim_value),
    .config0_value(config0_value), .config1_value(config1_value),
    .config2_value(config2_value));
  stss_link_sva i_stss_link_sva (.pclk(pclk), .presetn(presetn), .spi_en(link.spi_en),
    .external_core_reset_n(link.external_core_reset_n), .sck(link.sck), .ncs(link.ncs),
    .mosi(link.mosi), .miso_out(link.miso_out), .miso_oe_n(link.miso_oe_n), .miso(link.miso));

  // 50 ns period
  always #25 pclk = ~pclk;

  // acquisition triggers are single-cycle, so count them as they pass
  always @(posedge pclk) begin
    if (acquire_pulse === 1'b1) acq_cnt++;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one serial frame through the controller, result left in rd
  task frame(input logic [7:0] op, input logic [7:0] ad, input logic [15:0] wd);
    int n;
    n = 0;
    apb(1'b1, APB_CMD, {16'h0000, ad, op});
    apb(1'b1, APB_WDATA, {16'h0000, wd});
    apb(1'b1, APB_CTRL, 32'h0000_0007);
    do begin
      apb(1'b0, APB_STATUS, 32'h0);
      n++;
    end while (r[0] === 1'b1 && n < 4000);
    // a frame that never ends counts as a mismatch, not a silent pass
    if (r[0] !== 1'b0) begin
      error_cnt++;
      $display("[ERR] frame end expected 0 seen %b", r[0]);
    end
    apb(1'b0, APB_RDATA, 32'h0);
    rd = r[15:0];
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("test after reset", TEST_RESET, test_value);
    chk("radio in radio mode", 16'h0001, 16'(radio_enable));
    chk("data out in radio mode", 16'h0000, 16'(link.miso));
    apb(1'b1, APB_CTRL, 32'h0000_0002);
    repeat (8) @(posedge pclk);
    chk("radio in serial mode", 16'h0000, 16'(radio_enable));
    chk("external clock select", 16'h0001, 16'(ext_clock_select));
    apb(1'b1, APB_CTRL, 32'h0000_0006);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", 16'h0001, 16'(perr));
    // write to a read-only place must leave it alone
    frame(OP_REG_WRITE, REG_SENSOR, 16'hFFFF);
    for (int a = 1; a <= 6; a++) begin
      frame(OP_REG_READ, 8'(a), 16'h0000);
      chk("read-only register", exp_ro[a], rd);
    end
    for (int i = 0; i < 4; i++) begin
      frame(OP_REG_WRITE, REG_TRIM0 + 8'(i), 16'h0101 * 16'(i + 1));
    end
    chk("trim", 16'h0101, trim_value);
    chk("config0", 16'h0202, config0_value);
    chk("config1", 16'h0303, config1_value);
    chk("config2", 16'h0404, config2_value);
    frame(OP_REG_WRITE, REG_TEST, 16'h8001);
    chk("test written", 16'h8001, test_value);
    chk("acquire pulses", 16'h0001, 16'(acq_cnt));
    // memory write at offset zero must not reach the test or config registers
    frame(OP_MEM_WRITE, 8'h00, 16'hBEEF);
    frame(OP_STATUS_READ, 8'h00, 16'h0000);
    chk("status while busy", 16'h0001, {8'h00, rd[7:0]});
    chk("test after memory write", 16'h8001, test_value);
    chk("config0 after memory write", 16'h0202, config0_value);
    frame(OP_MEM_WRITE, 8'h21, 16'h0F0F);
    frame(OP_MEM_READ, 8'h00, 16'h0000);
    chk("read while busy", 16'h0000, rd);
    frame(OP_STATUS_READ, 8'h00, 16'h0000);
    chk("status when idle", 16'h0000, {8'h00, rd[7:0]});
    frame(8'h55, 8'h00, 16'hFFFF);
    chk("unknown opcode", 16'h0000, rd);
    frame(OP_MEM_READ, 8'h00, 16'h0000);
    chk("memory read", 16'hBEEF, rd);
    close_out();
  end

  // the frames above take near 93000 cycles
  initial begin
    repeat (100000) @(posedge pclk);
    error_cnt++;
    $display("[ERR] watchdog expected finish seen hang");
    close_out();
  end
endmodule
